// ==== design/pbao_in_sync.sv ====
// Input register stage for the three ports' pin levels
`timescale 1ns/100ps
module pbao_in_sync (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic [23:0] pins_in,
  output logic [23:0]      pins_q
);
  import pbao_pkg::*;

  typedef struct packed {
    logic [23:0] q;
  } pbao_sync_state_s;

  pbao_sync_state_s state_reg;
  pbao_sync_state_s state_next;

  always_comb begin
    state_next   = state_reg;
    state_next.q = pins_in;
    if (reset) begin
      state_next.q = {3{RESET_BYTE}};
    end
  end

  always_ff @(posedge clk) begin
    state_reg <= state_next;
  end

  assign pins_q = state_reg.q;

endmodule

// ==== design/pbao_pin_resolve.sv ====
// Per-port override resolver: merges override set with port registers
`timescale 1ns/100ps
module pbao_pin_resolve (
  input  pbao_pkg::pbao_port_regs_s regs,
  input  pbao_pkg::pbao_ovr_s       ovr,
  input  wire logic                 global_pullup_off,
  input  wire logic [7:0]           pin_in,
  output pbao_pkg::pbao_pin_ctl_s   ctl,
  output logic [7:0]                din
);
  import pbao_pkg::*;

  genvar i;
  generate
    for (i = 0; i < PORT_W; i++) begin : g_pin
      logic dir_eff;
      logic val_eff;
      logic ie_eff;
      assign dir_eff = ovr.direction_override_en[i] ?
                       ovr.direction_override_val[i] : regs.dir[i];
      assign val_eff = ovr.pin_value_override_en[i] ?
                       ovr.pin_value_override_val[i] : regs.out[i];
      assign ie_eff  = ovr.input_enable_override_en[i] ?
                       ovr.input_enable_override_val[i] : 1'b1;
      assign ctl.drive_en[i]  = dir_eff;
      assign ctl.drive_val[i] = val_eff;
      // Pull-up from the override where enabled, else only on an input pin with its out bit set
      assign ctl.pullup_en[i] = ovr.pullup_override_en[i] ?
                                ovr.pullup_override_val[i] :
                                (~dir_eff & regs.out[i] & ~global_pullup_off);
      assign din[i] = pin_in[i] & ie_eff;
    end
  endgenerate

endmodule

// ==== design/pbao_pkg.sv ====
// Package: constants and carrier structs for the port B/C/D override logic
package pbao_pkg;

  localparam int PORT_W       = 8;
  localparam int MASK_W       = 3;
  localparam int TICK_NS      = 40;

  // Port B bit positions
  localparam int PB_SS_BIT    = 0;
  localparam int PB_SCK_BIT   = 1;
  localparam int PB_MOSI_BIT  = 2;
  localparam int PB_MISO_BIT  = 3;
  localparam int PB_OC0_BIT   = 4;
  localparam int PB_TIMER_ONE_COMPARE_A_OUT_BIT  = 5;
  localparam int PB_TIMER_ONE_COMPARE_B_OUT_BIT  = 6;
  localparam int PB_OC7_BIT   = 7;

  // Port D bit positions
  localparam int PD_SCL_BIT   = 0;
  localparam int PD_SDA_BIT   = 1;
  localparam int PD_RX_BIT    = 2;
  localparam int PD_TX_BIT    = 3;
  localparam int PD_ICP_BIT   = 4;
  localparam int PD_XCK_BIT   = 5;
  localparam int PD_T1_BIT    = 6;
  localparam int PD_T2_BIT    = 7;

  // Port C release thresholds, indexed by pin
  localparam logic [MASK_W-1:0] PC_THRESH [PORT_W] = '{
    3'h7, 3'h7, 3'h6, 3'h5, 3'h4, 3'h3, 3'h2, 3'h1};
  localparam logic [MASK_W-1:0] LEGACY_MASK = 3'h0;

  localparam logic [PORT_W-1:0] RESET_BYTE = 8'h00;

  // Port register view of one port
  typedef struct packed {
    logic [PORT_W-1:0] dir;
    logic [PORT_W-1:0] out;
  } pbao_port_regs_s;

  // Resolved pin control of one port
  typedef struct packed {
    logic [PORT_W-1:0] drive_en;
    logic [PORT_W-1:0] drive_val;
    logic [PORT_W-1:0] pullup_en;
  } pbao_pin_ctl_s;

  // Per-pin override set
  typedef struct packed {
    logic [PORT_W-1:0] pullup_override_en;
    logic [PORT_W-1:0] pullup_override_val;
    logic [PORT_W-1:0] direction_override_en;
    logic [PORT_W-1:0] direction_override_val;
    logic [PORT_W-1:0] pin_value_override_en;
    logic [PORT_W-1:0] pin_value_override_val;
    logic [PORT_W-1:0] input_enable_override_en;
    logic [PORT_W-1:0] input_enable_override_val;
  } pbao_ovr_s;

  // SPI side
  typedef struct packed {
    logic serial_periph_on;
    logic serial_master_select;
    logic slave_out;
    logic serial_master_out_path;
    logic sck_out;
  } pbao_spi_s;

  typedef struct packed {
    logic serial_master_in_path;
    logic slave_in;
    logic sck_in;
    logic ss_in;
    logic slave_active;
  } pbao_spi_in_s;

  // Timer compare outputs, port B bits 7..4
  typedef struct packed {
    logic timer_two_compare_out;
    logic timer_two_compare_en;
    logic timer_one_compare_c_out;
    logic timer_one_compare_c_en;
    logic timer_one_compare_b_out;
    logic timer_one_compare_b_en;
    logic timer_one_compare_a_out;
    logic timer_one_compare_a_en;
    logic timer_zero_compare_out;
    logic timer_zero_compare_en;
  } pbao_cmp_s;

  // Port D peripherals
  typedef struct packed {
    logic usart_b_sync_mode;
    logic usart_b_sync_clock;
    logic uart_b_tx_on;
    logic uart_b_transmit;
    logic uart_b_rx_on;
    logic twi_on;
    logic sda_out;
    logic scl_out;
    logic [3:0] ext_irq_on;
  } pbao_pd_s;

  typedef struct packed {
    logic timer_two_clock_in;
    logic timer_one_clock_in;
    logic timer_one_capture_in;
    logic usart_b_clock_in;
    logic uart_b_receive;
    logic sda_in;
    logic scl_in;
    logic [3:0] ext_irq_in;
  } pbao_pd_in_s;

endpackage

// ==== design/pbao_top.sv ====
// Alternate-function override logic for ports B, C and D
// Function
// - SPI slave forces slave-select pin input
// - Slave SPI active only while select low
// - SPI master leaves select direction to port
// - Forced inputs keep port-bit pull-up, gated
// - MISO/MOSI split into master and slave paths
// - Drive slave, master, clock outputs; never SS
// - Port B bits 3..0 feed SPI inputs
// - Compare outputs replace port B 7..4 values
// - SPI master forces MISO to input
// - Port C carries address bits 15..8
// - Port C released by mask threshold compare
// - Legacy mode: port C output only
// - Legacy mode: mask treated as zero
// - Port D 7,6,4 feed timer clocks, capture
// - Sync clock pin direction from port bit
// - Sync clock active only in sync mode
// - Port D 3..0 shared irq, UART, two-wire
// - Legacy mode omits USART, TWI, compare C
`timescale 1ns/100ps
module pbao_top (
  input  wire logic                 clk,
  input  wire logic                 reset,
  input  wire logic                 legacy_mode,
  input  wire logic                 global_pullup_off,
  input  wire logic                 ext_memory_on,
  input  wire logic [2:0]           high_addr_release_mask,
  input  wire logic [7:0]           ext_addr_high,
  input  pbao_pkg::pbao_port_regs_s portb_regs,
  input  pbao_pkg::pbao_port_regs_s portc_regs,
  input  pbao_pkg::pbao_port_regs_s portd_regs,
  input  pbao_pkg::pbao_spi_s       spi,
  input  pbao_pkg::pbao_cmp_s       cmp,
  input  pbao_pkg::pbao_pd_s        pd,
  input  wire logic [7:0]           portb_pin_in,
  input  wire logic [7:0]           portc_pin_in,
  input  wire logic [7:0]           portd_pin_in,
  output pbao_pkg::pbao_pin_ctl_s   portb_ctl,
  output pbao_pkg::pbao_pin_ctl_s   portc_ctl,
  output pbao_pkg::pbao_pin_ctl_s   portd_ctl,
  output logic [7:0]                portb_din,
  output logic [7:0]                portc_din,
  output logic [7:0]                portd_din,
  output pbao_pkg::pbao_spi_in_s    spi_in,
  output pbao_pkg::pbao_pd_in_s     pd_in
);
  import pbao_pkg::*;

  // Every output of the block, registered as one word
  typedef struct packed {
    pbao_pin_ctl_s b_ctl;
    pbao_pin_ctl_s c_ctl;
    pbao_pin_ctl_s d_ctl;
    logic [7:0]    b_din;
    logic [7:0]    c_din;
    logic [7:0]    d_din;
    pbao_spi_in_s  spi_in;
    pbao_pd_in_s   pd_in;
  } pbao_state_s;

  // Registered output word and its next value
  pbao_state_s   state_reg;
  pbao_state_s   state_next;

  // Override sets of the three ports
  pbao_ovr_s     ovr_b;
  pbao_ovr_s     ovr_c;
  pbao_ovr_s     ovr_d;

  // Resolved controls ahead of the output register
  pbao_pin_ctl_s b_ctl_c;
  pbao_pin_ctl_s c_ctl_c;
  pbao_pin_ctl_s d_ctl_c;
  logic [7:0]    b_din_c;
  logic [7:0]    c_din_c;
  logic [7:0]    d_din_c;

  // Pin levels after the input register, port D on top
  logic [23:0]   pins_q;

  // Function enables after role and legacy gating
  logic          spi_master;
  logic          spi_slave;
  logic [2:0]    mask_eff;
  logic          sync_clk_on;
  logic          tx_on;
  logic          rx_on;
  logic          twi_on;
  logic          c_out_on;

  // Pins pass one register before any use
  pbao_in_sync u_in_sync (
    .clk     (clk),
    .reset   (reset),
    .pins_in ({portd_pin_in, portc_pin_in, portb_pin_in}),
    .pins_q  (pins_q)
  );

  // SPI role from enable and master select
  assign spi_master  = spi.serial_periph_on & spi.serial_master_select;
  assign spi_slave   = spi.serial_periph_on & ~spi.serial_master_select;

  // Legacy mode strips the later functions
  assign mask_eff    = legacy_mode ? LEGACY_MASK : high_addr_release_mask;
  assign sync_clk_on = pd.usart_b_sync_mode & ~legacy_mode;
  assign tx_on       = pd.uart_b_tx_on & ~legacy_mode;
  assign rx_on       = pd.uart_b_rx_on & ~legacy_mode;
  assign twi_on      = pd.twi_on & ~legacy_mode;
  assign c_out_on    = cmp.timer_one_compare_c_en & ~legacy_mode;

  // Port B overrides
  always_comb begin
    // Start from no override on any pin
    ovr_b = '0;

    // SPI pins bits 3..0: forced input for the receiving role
    // Bit 3 listens as master; bits 2..0 listen as slave
    ovr_b.pullup_override_en[PB_MISO_BIT]  = spi_master;
    ovr_b.direction_override_en[PB_MISO_BIT] = spi_master;
    ovr_b.pullup_override_en[PB_MOSI_BIT]  = spi_slave;
    ovr_b.direction_override_en[PB_MOSI_BIT] = spi_slave;
    ovr_b.pullup_override_en[PB_SCK_BIT]   = spi_slave;
    ovr_b.direction_override_en[PB_SCK_BIT] = spi_slave;
    ovr_b.pullup_override_en[PB_SS_BIT]    = spi_slave;
    ovr_b.direction_override_en[PB_SS_BIT] = spi_slave;

    // Forced inputs keep the port-bit pull-up, gated globally
    for (int i = 0; i < 4; i++) begin
      ovr_b.pullup_override_val[i] = portb_regs.out[i] & ~global_pullup_off;
      ovr_b.direction_override_val[i] = 1'b0;
      ovr_b.input_enable_override_en[i] = 1'b0;
    end

    // Outputs of the driving role; SS value never overridden
    ovr_b.pin_value_override_en[PB_MISO_BIT]  = spi_slave;
    ovr_b.pin_value_override_val[PB_MISO_BIT] = spi.slave_out;
    ovr_b.pin_value_override_en[PB_MOSI_BIT]  = spi_master;
    ovr_b.pin_value_override_val[PB_MOSI_BIT] = spi.serial_master_out_path;
    ovr_b.pin_value_override_en[PB_SCK_BIT]   = spi_master;
    ovr_b.pin_value_override_val[PB_SCK_BIT]  = spi.sck_out;

    // Compare outputs bits 7..4
    // Direction and pull-up stay with the port bits
    ovr_b.pin_value_override_en[PB_OC0_BIT]   = cmp.timer_zero_compare_en;
    ovr_b.pin_value_override_val[PB_OC0_BIT]  = cmp.timer_zero_compare_out;
    ovr_b.pin_value_override_en[PB_TIMER_ONE_COMPARE_A_OUT_BIT]  = cmp.timer_one_compare_a_en;
    ovr_b.pin_value_override_val[PB_TIMER_ONE_COMPARE_A_OUT_BIT] = cmp.timer_one_compare_a_out;
    ovr_b.pin_value_override_en[PB_TIMER_ONE_COMPARE_B_OUT_BIT]  = cmp.timer_one_compare_b_en;
    ovr_b.pin_value_override_val[PB_TIMER_ONE_COMPARE_B_OUT_BIT] = cmp.timer_one_compare_b_out;

    // Bit 7 merges both compare units; C unit absent in legacy mode
    ovr_b.pin_value_override_en[PB_OC7_BIT]   =
      cmp.timer_two_compare_en | c_out_on;
    ovr_b.pin_value_override_val[PB_OC7_BIT]  =
      (cmp.timer_two_compare_en & cmp.timer_two_compare_out) |
      (c_out_on & cmp.timer_one_compare_c_out);
  end

  // Port C overrides: address high byte
  always_comb begin
    ovr_c = '0;

    // Pin i carries address bit 8 + i
    for (int i = 0; i < PORT_W; i++) begin
      logic rel;

      // Released pins carry address: output, no pull-up
      rel = ext_memory_on & (mask_eff < PC_THRESH[i]);
      ovr_c.pullup_override_en[i]     = rel;
      ovr_c.pullup_override_val[i]    = 1'b0;
      ovr_c.direction_override_en[i]  = rel | legacy_mode;
      ovr_c.direction_override_val[i] = 1'b1;
      ovr_c.pin_value_override_en[i]  = rel;
      ovr_c.pin_value_override_val[i] = ext_addr_high[i];
    end
  end

  // Port D overrides
  always_comb begin
    ovr_d = '0;

    // Bit 5: sync clock value only; direction from port bit
    ovr_d.pin_value_override_en[PD_XCK_BIT]  = sync_clk_on;
    ovr_d.pin_value_override_val[PD_XCK_BIT] = pd.usart_b_sync_clock;

    // Bit 3: transmitter owns the pin
    ovr_d.pullup_override_en[PD_TX_BIT]      = tx_on;
    ovr_d.direction_override_en[PD_TX_BIT]   = tx_on;
    ovr_d.direction_override_val[PD_TX_BIT]  = 1'b1;
    ovr_d.pin_value_override_en[PD_TX_BIT]   = tx_on;
    ovr_d.pin_value_override_val[PD_TX_BIT]  = pd.uart_b_transmit;

    // Bit 2: receiver forces input, pull-up from port bit
    ovr_d.pullup_override_en[PD_RX_BIT]      = rx_on;
    ovr_d.pullup_override_val[PD_RX_BIT]     =
      portd_regs.out[PD_RX_BIT] & ~global_pullup_off;
    ovr_d.direction_override_en[PD_RX_BIT]   = rx_on;

    // Bits 1, 0: open-drain two-wire, value held low
    ovr_d.pullup_override_en[PD_SDA_BIT]     = twi_on;
    ovr_d.pullup_override_val[PD_SDA_BIT]    =
      portd_regs.out[PD_SDA_BIT] & ~global_pullup_off;
    ovr_d.direction_override_en[PD_SDA_BIT]  = twi_on;
    ovr_d.direction_override_val[PD_SDA_BIT] = pd.sda_out;
    ovr_d.pin_value_override_en[PD_SDA_BIT]  = twi_on;

    ovr_d.pullup_override_en[PD_SCL_BIT]     = twi_on;
    ovr_d.pullup_override_val[PD_SCL_BIT]    =
      portd_regs.out[PD_SCL_BIT] & ~global_pullup_off;
    ovr_d.direction_override_en[PD_SCL_BIT]  = twi_on;
    ovr_d.direction_override_val[PD_SCL_BIT] = pd.scl_out;
    ovr_d.pin_value_override_en[PD_SCL_BIT]  = twi_on;

    // Bits 3..0: interrupt inputs keep their input path
    for (int i = 0; i < 4; i++) begin
      ovr_d.input_enable_override_en[i]  = pd.ext_irq_on[i];
      ovr_d.input_enable_override_val[i] = 1'b1;
    end
  end

  // One resolver per port merges overrides with port bits
  // Port B: SPI and compare outputs
  pbao_pin_resolve u_res_b (
    .regs              (portb_regs),
    .ovr               (ovr_b),
    .global_pullup_off (global_pullup_off),
    .pin_in            (pins_q[7:0]),
    .ctl               (b_ctl_c),
    .din               (b_din_c)
  );

  // Port C: address high byte
  pbao_pin_resolve u_res_c (
    .regs              (portc_regs),
    .ovr               (ovr_c),
    .global_pullup_off (global_pullup_off),
    .pin_in            (pins_q[15:8]),
    .ctl               (c_ctl_c),
    .din               (c_din_c)
  );

  // Port D: timers, USART, two-wire, interrupts
  pbao_pin_resolve u_res_d (
    .regs              (portd_regs),
    .ovr               (ovr_d),
    .global_pullup_off (global_pullup_off),
    .pin_in            (pins_q[23:16]),
    .ctl               (d_ctl_c),
    .din               (d_din_c)
  );

  always_comb begin
    state_next = state_reg;

    // Pin controls and gated pin inputs
    state_next.b_ctl = b_ctl_c;
    state_next.c_ctl = c_ctl_c;
    state_next.d_ctl = d_ctl_c;
    state_next.b_din = b_din_c;
    state_next.c_din = legacy_mode ? RESET_BYTE : c_din_c;
    state_next.d_din = d_din_c;

    // SPI inputs, bits 3..0 of port B
    state_next.spi_in.serial_master_in_path = b_din_c[PB_MISO_BIT];
    state_next.spi_in.slave_in              = b_din_c[PB_MOSI_BIT];
    state_next.spi_in.sck_in                = b_din_c[PB_SCK_BIT];
    state_next.spi_in.ss_in                 = b_din_c[PB_SS_BIT];
    state_next.spi_in.slave_active          = spi_slave & ~b_din_c[PB_SS_BIT];

    // Peripheral inputs from port D
    state_next.pd_in.timer_two_clock_in     = d_din_c[PD_T2_BIT];
    state_next.pd_in.timer_one_clock_in     = d_din_c[PD_T1_BIT];
    state_next.pd_in.timer_one_capture_in   = d_din_c[PD_ICP_BIT];
    state_next.pd_in.usart_b_clock_in       = d_din_c[PD_XCK_BIT] & sync_clk_on;
    state_next.pd_in.uart_b_receive         = d_din_c[PD_RX_BIT] & rx_on;
    state_next.pd_in.sda_in                 = pins_q[16+PD_SDA_BIT] & twi_on;
    state_next.pd_in.scl_in                 = pins_q[16+PD_SCL_BIT] & twi_on;
    state_next.pd_in.ext_irq_in             = d_din_c[3:0];

    // Synchronous reset clears every output
    if (reset) begin
      state_next = '0;
    end
  end

  // Single output register stage
  always_ff @(posedge clk) begin
    state_reg <= state_next;
  end

  // Outputs straight from the register
  assign portb_ctl = state_reg.b_ctl;
  assign portc_ctl = state_reg.c_ctl;
  assign portd_ctl = state_reg.d_ctl;
  assign portb_din = state_reg.b_din;
  assign portc_din = state_reg.c_din;
  assign portd_din = state_reg.d_din;
  assign spi_in    = state_reg.spi_in;
  assign pd_in     = state_reg.pd_in;

endmodule

// ==== verification/pbao_pin_model.sv ====
// Partner: pad drivers that settle one port's pin levels
`timescale 1ns/100ps
module pbao_pin_model (
  input wire logic               clk,
  input pbao_pkg::pbao_pin_ctl_s ctl,
  input wire logic [7:0]         ext_en,
  input wire logic [7:0]         ext_val,
  output logic [7:0]             pin
);
  import pbao_pkg::*;
  logic [7:0] last_reg = 8'h00;
  always_ff @(posedge clk) last_reg <= pin;
  // Undriven and unpulled pins float away from their last level
  always_comb begin
    for (int i = 0; i < PORT_W; i++) begin
      if (ctl.drive_en[i]) pin[i] = ctl.drive_val[i];
      else if (ext_en[i]) pin[i] = ext_val[i];
      else if (ctl.pullup_en[i]) pin[i] = 1'b1;
      else pin[i] = ~last_reg[i];
    end
  end
endmodule

// ==== verification/pbao_top_sva.sv ====
// Checker: timing and value relations of the port override outputs
`timescale 1ns/100ps
module pbao_top_sva (
  input wire logic                  clk,
  input wire logic                  reset,
  input wire logic                  legacy_mode,
  input wire logic                  global_pullup_off,
  input wire logic                  ext_memory_on,
  input wire logic [2:0]            high_addr_release_mask,
  input wire logic [7:0]            ext_addr_high,
  input pbao_pkg::pbao_port_regs_s  portb_regs,
  input pbao_pkg::pbao_port_regs_s  portd_regs,
  input pbao_pkg::pbao_spi_s        spi,
  input pbao_pkg::pbao_cmp_s        cmp,
  input pbao_pkg::pbao_pd_s         pd,
  input wire logic [7:0]            portb_pin_in,
  input pbao_pkg::pbao_pin_ctl_s    portb_ctl,
  input pbao_pkg::pbao_pin_ctl_s    portc_ctl,
  input pbao_pkg::pbao_pin_ctl_s    portd_ctl,
  input pbao_pkg::pbao_spi_in_s     spi_in
);
  import pbao_pkg::*;
  logic [1:0] live_reg;
  logic [7:0] rel;
  logic       slv;
  logic       mst;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  assign slv = spi.serial_periph_on & ~spi.serial_master_select;
  assign mst = spi.serial_periph_on & spi.serial_master_select;
  always_comb begin
    for (int i = 0; i < PORT_W; i++) begin
      rel[i] = ext_memory_on &
               ((legacy_mode ? LEGACY_MASK : high_addr_release_mask) < PC_THRESH[i]);
    end
  end
  // Pin-derived outputs are valid two edges after reset release
  always_ff @(posedge clk) begin
    if (reset) begin
      live_reg <= 2'h0;
    end else if (live_reg != 2'h3) begin
      live_reg <= live_reg + 2'h1;
    end
  end
  ss_slave_input_a: assert property (slv |=> !portb_ctl.drive_en[0])
    else $error("slave-select pin driven in slave mode");
  slave_active_a: assert property (live_reg[1] |-> spi_in.slave_active ==
    ($past(slv) && !$past(portb_pin_in[0], 2))) else $error("slave active flag wrong");
  master_ss_port_a: assert property (mst |=> portb_ctl.drive_en[0] ==
    $past(portb_regs.dir[0]) && portb_ctl.drive_val[0] == $past(portb_regs.out[0]))
    else $error("select pin not under port control in master mode");
  miso_master_in_a: assert property (mst |=> !portb_ctl.drive_en[3] &&
    portb_ctl.pullup_en[3] == $past(portb_regs.out[3] & ~global_pullup_off))
    else $error("data-in pin not input with port pull-up in master mode");
  mosi_drive_a: assert property (mst && portb_regs.dir[2] |=> portb_ctl.drive_en[2]
    && portb_ctl.drive_val[2] == $past(spi.serial_master_out_path))
    else $error("master data not driven on its pin");
  compare_out_a: assert property (cmp.timer_zero_compare_en && portb_regs.dir[4] |=>
    portb_ctl.drive_en[4] && portb_ctl.drive_val[4] == $past(cmp.timer_zero_compare_out))
    else $error("compare output not on its pin");
  addr_release_a: assert property (|rel |=> (portc_ctl.drive_en & $past(rel)) ==
    $past(rel) && (portc_ctl.drive_val & $past(rel)) == $past(ext_addr_high & rel)
    && (portc_ctl.pullup_en & $past(rel)) == 8'h00) else $error("address pins not released");
  sync_clock_a: assert property (pd.usart_b_sync_mode && !legacy_mode && portd_regs.dir[5]
    |=> portd_ctl.drive_en[5] && portd_ctl.drive_val[5] == $past(pd.usart_b_sync_clock))
    else $error("sync clock not driven on its pin");
  cover property (slv && !portb_pin_in[0]);
  cover property (mst && portb_regs.dir[2]);
  cover property (|rel && legacy_mode);
endmodule

// ==== verification/testbench.sv ====
// Testbench: random and corner stimulus for the port override logic
`timescale 1ns/100ps
module testbench;
  import pbao_pkg::*;
  typedef struct packed {
    logic leg, gpo, xmem;
    logic [2:0] mask;
    logic [7:0] addr;
    pbao_port_regs_s rb, rc, rd;
    pbao_spi_s sp;
    pbao_cmp_s cm;
    pbao_pd_s pd;
    logic [7:0] xb, xc, xd;
  } pbao_stim_s;
  logic            clk = 1'b0;
  logic            reset = 1'b1;
  pbao_stim_s      st = '0;
  logic [31:0]     lfsr = 32'h00017430;
  pbao_pin_ctl_s   portb_ctl, portc_ctl, portd_ctl;
  logic [7:0]      portb_din, portc_din, portd_din, pin_b, pin_c, pin_d;
  pbao_spi_in_s    spi_in;
  pbao_pd_in_s     pd_in;
  int              n_errors = 0;
  int              compares = 0;
  always #20 clk = ~clk;
  pbao_top u_dut (.clk(clk), .reset(reset), .legacy_mode(st.leg), .global_pullup_off(st.gpo),
    .ext_memory_on(st.xmem), .high_addr_release_mask(st.mask), .ext_addr_high(st.addr),
    .portb_regs(st.rb), .portc_regs(st.rc), .portd_regs(st.rd), .spi(st.sp), .cmp(st.cm),
    .pd(st.pd), .portb_pin_in(pin_b), .portc_pin_in(pin_c), .portd_pin_in(pin_d),
    .portb_ctl(portb_ctl), .portc_ctl(portc_ctl), .portd_ctl(portd_ctl), .portb_din(portb_din),
    .portc_din(portc_din), .portd_din(portd_din), .spi_in(spi_in), .pd_in(pd_in));
  pbao_pin_model u_pads_b (.clk(clk), .ctl(portb_ctl), .ext_en(8'hff), .ext_val(st.xb),
    .pin(pin_b));
  pbao_pin_model u_pads_c (.clk(clk), .ctl(portc_ctl), .ext_en(8'hff), .ext_val(st.xc),
    .pin(pin_c));
  pbao_pin_model u_pads_d (.clk(clk), .ctl(portd_ctl), .ext_en(8'hff), .ext_val(st.xd),
    .pin(pin_d));
  function automatic pbao_stim_s draw();
    for (int i = 0; i < $bits(pbao_stim_s); i++) begin
      lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
      draw[i] = lfsr[0];
    end
  endfunction
  function automatic logic sel(logic en, logic v, logic o);
    return en ? v : o;
  endfunction
  function automatic pbao_pin_ctl_s res(logic [7:0] den, logic [7:0] val, logic [7:0] out);
    res.drive_en  = den;
    res.drive_val = val & den;
    res.pullup_en = ~den & out & ~{8{st.gpo}};
  endfunction
  function automatic logic [23:0] view(pbao_pin_ctl_s c, pbao_pin_ctl_s e);
    return {c.drive_en, c.drive_val & e.drive_en, c.pullup_en};
  endfunction
  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out();
    if (n_errors == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic check_all();
    pbao_pin_ctl_s eb, ec, ed;
    pbao_cmp_s     c;
    pbao_pd_s      p;
    logic [7:0]    pb, pc, pdl, rel, ob, od;
    logic          slv, mst, lv, tx, rx, tw, sy;
    c = st.cm;
    p = st.pd;
    ob = st.rb.out;
    od = st.rd.out;
    slv = st.sp.serial_periph_on & ~st.sp.serial_master_select;
    mst = st.sp.serial_periph_on & st.sp.serial_master_select;
    lv = ~st.leg;
    tx = p.uart_b_tx_on & lv;
    rx = p.uart_b_rx_on & lv;
    tw = p.twi_on & lv;
    sy = p.usart_b_sync_mode & lv;
    for (int i = 0; i < PORT_W; i++) begin
      rel[i] = st.xmem & ((st.leg ? LEGACY_MASK : st.mask) < PC_THRESH[i]);
    end
    eb = res({st.rb.dir[7:4], st.rb.dir[3] & ~mst, st.rb.dir[2:0] & ~{3{slv}}},
      {sel(c.timer_two_compare_en, c.timer_two_compare_out,
        sel(c.timer_one_compare_c_en & lv, c.timer_one_compare_c_out, ob[7])),
       sel(c.timer_one_compare_b_en, c.timer_one_compare_b_out, ob[6]),
       sel(c.timer_one_compare_a_en, c.timer_one_compare_a_out, ob[5]),
       sel(c.timer_zero_compare_en, c.timer_zero_compare_out, ob[4]),
       sel(slv, st.sp.slave_out, ob[3]), sel(mst, st.sp.serial_master_out_path, ob[2]),
       sel(mst, st.sp.sck_out, ob[1]), ob[0]}, ob);
    ec = res(rel | {8{st.leg}} | st.rc.dir, (rel & st.addr) | (~rel & st.rc.out), st.rc.out);
    ed = res({st.rd.dir[7:4], st.rd.dir[3] | tx, st.rd.dir[2] & ~rx,
      sel(tw, p.sda_out, st.rd.dir[1]), sel(tw, p.scl_out, st.rd.dir[0])},
      {od[7:6], sel(sy, p.usart_b_sync_clock, od[5]), od[4], sel(tx, p.uart_b_transmit, od[3]),
       od[2], od[1:0] & ~{2{tw}}}, od);
    // Two-wire pins keep the port-bit pull-up whatever their direction
    if (tw) begin
      ed.pullup_en[1:0] = od[1:0] & ~{2{st.gpo}};
    end
    pb = eb.drive_val | (~eb.drive_en & st.xb);
    pc = ec.drive_val | (~ec.drive_en & st.xc);
    pdl = ed.drive_val | (~ed.drive_en & st.xd);
    check("portb_ctl", view(portb_ctl, eb), eb);
    check("portc_ctl", view(portc_ctl, ec), ec);
    check("portd_ctl", view(portd_ctl, ed), ed);
    check("portb_din", portb_din, pb);
    check("portc_din", portc_din, st.leg ? 8'h00 : pc);
    check("portd_din", portd_din, pdl);
    check("spi_in", spi_in, {pb[3:0], slv & ~pb[0]});
    check("pd_in", pd_in, {pdl[7:6], pdl[4], pdl[5] & sy, pdl[2] & rx, pdl[1:0] & {2{tw}},
      pdl[3:0]});
  endtask
  // Holds one vector long enough for the pin loop and input stage to settle
  task automatic run(input pbao_stim_s s);
    s.cm.timer_one_compare_c_en &= ~s.cm.timer_two_compare_en;
    @(negedge clk);
    st = s;
    repeat (4) @(negedge clk);
    check_all();
  endtask
  initial begin
    pbao_stim_s s;
    repeat (20) @(negedge clk);
    reset = 1'b0;
    for (int m = 0; m < 4; m++) begin
      s = draw();
      s.sp.serial_periph_on = 1'b1;
      s.sp.serial_master_select = m[0];
      s.xb[0] = m[1];
      s.rb.dir = 8'hff;
      run(s);
    end
    for (int m = 0; m < 16; m++) begin
      s = draw();
      s.xmem = 1'b1;
      s.mask = m[2:0];
      s.leg = m[3];
      run(s);
    end
    s = '1;
    s.cm.timer_two_compare_en = 1'b0;
    run(s);
    repeat (200) run(draw());
    close_out();
  end
  // About 1125 cycles are needed; reaching 3000 means a hang
  initial begin
    repeat (3000) @(posedge clk);
    n_errors++;
    close_out();
  end
endmodule
bind pbao_top pbao_top_sva u_sva (.clk(clk), .reset(reset), .legacy_mode(legacy_mode),
  .global_pullup_off(global_pullup_off), .ext_memory_on(ext_memory_on),
  .high_addr_release_mask(high_addr_release_mask), .ext_addr_high(ext_addr_high),
  .portb_regs(portb_regs), .portd_regs(portd_regs), .spi(spi), .cmp(cmp), .pd(pd),
  .portb_pin_in(portb_pin_in), .portb_ctl(portb_ctl), .portc_ctl(portc_ctl),
  .portd_ctl(portd_ctl), .spi_in(spi_in));
